// *** rtl/kms_pkg.sv ***
// Purpose: shared constants and types for the key matrix scanner
// Assumes: 100 MHz mclk_i
// Notes:   key bit n-1 is front-panel key n for keys 1..18, bit 18 is key 21
package kms_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int          KMS_LINES     = 6;
    localparam int          KMS_KEYS      = 19;
    localparam int          KMS_KEY_IDX_W = 5;
    localparam int          KMS_CNT_W     = 8;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int          KMS_CLK_PERIOD_NS = 10;
    // least time for the pulled-up lines to settle after a strobe change
    localparam int          KMS_SETTLE_NS     = 100;
    localparam int          KMS_SETTLE_CYC    =
        (KMS_SETTLE_NS + KMS_CLK_PERIOD_NS - 1) / KMS_CLK_PERIOD_NS;
    // edges from pin change to stable value, plus one for the strobe flop
    localparam int          KMS_MIN_SETTLE    = 5;

    // ----------------------------------------------------------------
    // reset values and codes
    // ----------------------------------------------------------------
    localparam logic [5:0]  KMS_LINES_IDLE = 6'h3f;
    localparam logic [18:0] KMS_KEYS_NONE  = 19'h00000;
    localparam logic [4:0]  KMS_NO_KEY     = 5'h1f;

    typedef enum logic [2:0] {
        KMS_STEP_1 = 3'b000,
        KMS_STEP_2 = 3'b001,
        KMS_STEP_3 = 3'b010,
        KMS_STEP_4 = 3'b011,
        KMS_STEP_5 = 3'b100,
        KMS_STEP_6 = 3'b101
    } kms_step_type;

endpackage : kms_pkg

// *** rtl/kms_line_if.sv ***
// Purpose: carries raw and settled key line levels between scanner parts
// Assumes: one clock domain on the user side
// Notes:   bit k is key_line_(k+1)
`timescale 1ns/100ps
`default_nettype none

interface kms_line_if;
    logic [5:0] raw;
    logic [5:0] stable;

    modport syncer (input raw, output stable);
    modport user   (output raw, input stable);
endinterface : kms_line_if

`default_nettype wire

// *** rtl/kms_line_sync.sv ***
// Purpose: three-flop synchroniser with agreement filter for key lines
// Assumes: raw lines come from pins, outside the clock domain
// Notes:   stable bit follows only once stages two and three agree
`timescale 1ns/100ps
`default_nettype none

module kms_line_sync
    import kms_pkg::*;
(
    // clock, reset, enable
    input  wire logic    mclk_i,
    input  wire logic    sys_rst_i,
    input  wire logic    ce_i,
    // lines
    kms_line_if.syncer   lines
);

    typedef struct packed {
        logic [5:0] s1;
        logic [5:0] s2;
        logic [5:0] s3;
        logic [5:0] stable;
    } kms_sync_type;

    kms_sync_type st_r;
    kms_sync_type st_nxt;

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb begin
        st_nxt        = st_r;
        st_nxt.s1     = lines.raw;
        st_nxt.s2     = st_r.s1;
        st_nxt.s3     = st_r.s2;
        // a bit moves only where the two late stages agree
        st_nxt.stable = (st_r.s3 & ~(st_r.s2 ^ st_r.s3))
                      | (st_r.stable & (st_r.s2 ^ st_r.s3));
    end

    // --------------------------------------------------------------
    // registers
    // --------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            st_r <= '{KMS_LINES_IDLE, KMS_LINES_IDLE,
                      KMS_LINES_IDLE, KMS_LINES_IDLE};
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    assign lines.stable = st_r.stable;

endmodule : kms_line_sync

`default_nettype wire

// *** rtl/kms_scanner.sv ***
// Purpose: six-step scanner for a 19-key passive front-panel matrix
// Assumes: lines pulled up externally, keys short lines together or to ground
// Notes:   key_down_o refreshes once per full six-step pass
`timescale 1ns/100ps
`default_nettype none

module kms_scanner
    import kms_pkg::*;
#(
    parameter int SETTLE_CYC = KMS_SETTLE_CYC
)(
    // clock, reset, enable
    input  wire logic                 mclk_i,
    input  wire logic                 sys_rst_i,
    input  wire logic                 ce_i,
    // key lines, bit k is key_line_(k+1)
    input  wire logic [KMS_LINES-1:0] key_line_i,
    output logic      [KMS_LINES-1:0] key_line_o,
    output logic      [KMS_LINES-1:0] key_line_oe_n_o,
    // results
    output logic      [KMS_KEYS-1:0]  key_down_o,
    output logic                      scan_done_o,
    output logic      [2:0]           scan_step_o
);

    // --------------------------------------------------------------
    // elaboration checks
    // --------------------------------------------------------------
    if (SETTLE_CYC < KMS_MIN_SETTLE || SETTLE_CYC > 255) begin : g_chk
        $error("SETTLE_CYC out of range");
    end

    localparam logic [KMS_CNT_W-1:0] SETTLE_LAST =
        KMS_CNT_W'(SETTLE_CYC - 1);

    // --------------------------------------------------------------
    // key decode: step and line bit to key bit
    // --------------------------------------------------------------
    // each strobe column up to step four holds one key fewer; step five holds none, step six one
    function automatic logic [KMS_KEY_IDX_W-1:0] key_index(
        input kms_step_type step,
        input int unsigned  bitn
    );
        logic [KMS_KEY_IDX_W-1:0] idx;
        idx = KMS_NO_KEY;
        unique case (step)
            KMS_STEP_1: begin
                case (bitn)
                    5: idx = 5'h07;
                    4: idx = 5'h10;
                    3: idx = 5'h09;
                    2: idx = 5'h0b;
                    1: idx = 5'h11;
                    0: idx = 5'h0c;
                    default: idx = KMS_NO_KEY;
                endcase
            end
            KMS_STEP_2: begin
                case (bitn)
                    5: idx = 5'h00;
                    4: idx = 5'h01;
                    3: idx = 5'h02;
                    2: idx = 5'h03;
                    1: idx = 5'h0a;
                    default: idx = KMS_NO_KEY;
                endcase
            end
            KMS_STEP_3: begin
                case (bitn)
                    5: idx = 5'h06;
                    4: idx = 5'h08;
                    3: idx = 5'h04;
                    2: idx = 5'h05;
                    default: idx = KMS_NO_KEY;
                endcase
            end
            KMS_STEP_4: begin
                case (bitn)
                    5: idx = 5'h0d;
                    4: idx = 5'h0e;
                    3: idx = 5'h0f;
                    default: idx = KMS_NO_KEY;
                endcase
            end
            KMS_STEP_5: idx = KMS_NO_KEY;
            KMS_STEP_6: begin
                if (bitn == 5) begin
                    idx = 5'h12;
                end
            end
            default: idx = KMS_NO_KEY;
        endcase
        return idx;
    endfunction : key_index

    // --------------------------------------------------------------
    // line synchroniser
    // --------------------------------------------------------------
    kms_line_if lines ();

    assign lines.raw = key_line_i;

    kms_line_sync u_sync (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .lines     (lines)
    );

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    typedef struct packed {
        kms_step_type           step;
        logic [KMS_CNT_W-1:0]   cnt;
        logic [KMS_KEYS-1:0]    acc;
        logic [KMS_KEYS-1:0]    keys;
        logic                   done;
        logic [KMS_LINES-1:0]   oe_n;
    } kms_state_type;

    kms_state_type st_r;
    kms_state_type st_nxt;

    always_comb begin
        logic [KMS_KEY_IDX_W-1:0] idx;
        logic [KMS_KEYS-1:0]      hit;
        kms_step_type             nstep;
        idx   = KMS_NO_KEY;
        hit   = KMS_KEYS_NONE;
        nstep = st_r.step;
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        // only lines at or above the step number are sensed
        for (int unsigned b = 0; b < KMS_LINES; b++) begin
            idx = key_index(st_r.step, b);
            // released lines read one; low means a closed key
            if (b >= 32'(st_r.step) && idx != KMS_NO_KEY
                    && !lines.stable[b]) begin
                hit[idx] = 1'b1;
            end
        end
        if (st_r.cnt != SETTLE_LAST) begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end else begin
            // sample once per step, after the lines have settled
            st_nxt.cnt = '0;
            unique case (st_r.step)
                KMS_STEP_1: nstep = KMS_STEP_2;
                KMS_STEP_2: nstep = KMS_STEP_3;
                KMS_STEP_3: nstep = KMS_STEP_4;
                KMS_STEP_4: nstep = KMS_STEP_5;
                KMS_STEP_5: nstep = KMS_STEP_6;
                KMS_STEP_6: nstep = KMS_STEP_1;
                default:    nstep = KMS_STEP_1;
            endcase
            st_nxt.step = nstep;
            if (st_r.step == KMS_STEP_6) begin
                // publish the whole pass at once
                st_nxt.keys = st_r.acc | hit;
                st_nxt.acc  = KMS_KEYS_NONE;
                st_nxt.done = 1'b1;
            end else begin
                st_nxt.acc  = st_r.acc | hit;
            end
            // step one: all inputs; else one strobe low
            if (nstep == KMS_STEP_1) begin
                st_nxt.oe_n = KMS_LINES_IDLE;
            end else begin
                st_nxt.oe_n = ~(KMS_LINES'(1) << (32'(nstep) - 1));
            end
        end
    end

    // --------------------------------------------------------------
    // registers
    // --------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            st_r <= '{KMS_STEP_1, '0, KMS_KEYS_NONE, KMS_KEYS_NONE,
                      1'b0, KMS_LINES_IDLE};
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    // strobes only ever pull low; high comes from the pull-ups
    assign key_line_o      = '0;
    assign key_line_oe_n_o = st_r.oe_n;
    assign key_down_o      = st_r.keys;
    assign scan_done_o     = st_r.done;
    assign scan_step_o     = st_r.step;

endmodule : kms_scanner

`default_nettype wire

// *** tb/kms_scanner_properties.sv ***
// Purpose: port checker for kms_scanner
// Assumes: reset held at least two cycles
// Notes:   bind after the module
`timescale 1ns/100ps
`default_nettype none
module kms_scanner_properties
    import kms_pkg::*;
#(parameter int SETTLE_CYC = 5)(
    // all top ports
    input wire logic        mclk_i,
    input wire logic        sys_rst_i,
    input wire logic        ce_i,
    input wire logic [5:0]  key_line_i,
    input wire logic [5:0]  key_line_o,
    input wire logic [5:0]  key_line_oe_n_o,
    input wire logic [18:0] key_down_o,
    input wire logic        scan_done_o,
    input wire logic [2:0]  scan_step_o
);
    // ----------
    // enabled cycles per step, frozen cycles not counted
    // ----------
    logic [7:0] ecnt_r;
    logic       seen_r;
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ecnt_r <= 8'h00;
            seen_r <= 1'b0;
        end else if ($changed(scan_step_o)) begin
            ecnt_r <= {7'h00, ce_i};
            seen_r <= 1'b1;
        end else begin
            ecnt_r <= ecnt_r + {7'h00, ce_i};
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    step_one_idle_a: assert property (
        scan_step_o == 3'h0 |-> key_line_oe_n_o == 6'h3f)
        else $error("lines driven in step one");
    strobe_line_a: assert property (
        scan_step_o != 3'h0 |->
        key_line_oe_n_o == ~(6'h01 << (scan_step_o - 3'h1)))
        else $error("wrong strobe line");
    one_strobe_a: assert property (
        $countones(~key_line_oe_n_o) <= 1)
        else $error("more than one strobe");
    drive_low_a: assert property (
        key_line_o == 6'h00)
        else $error("strobe not driven low");
    step_order_a: assert property (
        $changed(scan_step_o) |-> scan_step_o ==
        (($past(scan_step_o) == 3'h5) ? 3'h0 : $past(scan_step_o) + 3'h1))
        else $error("step out of order");
    step_len_a: assert property (
        $changed(scan_step_o) && seen_r |-> ecnt_r == SETTLE_CYC)
        else $error("step length wrong");
    done_wrap_a: assert property (
        $rose(scan_done_o) |->
        scan_step_o == 3'h0 && $past(scan_step_o) == 3'h5)
        else $error("done not at pass end");
    done_pulse_a: assert property (
        scan_done_o && ce_i |=> !scan_done_o)
        else $error("done longer than one cycle");
    result_hold_a: assert property (
        !scan_done_o |-> $stable(key_down_o))
        else $error("keys changed without done");
endmodule : kms_scanner_properties
bind kms_scanner kms_scanner_properties #(.SETTLE_CYC(SETTLE_CYC))
    kms_scanner_properties_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .ce_i(ce_i), .key_line_i(key_line_i), .key_line_o(key_line_o),
    .key_line_oe_n_o(key_line_oe_n_o), .key_down_o(key_down_o),
    .scan_done_o(scan_done_o), .scan_step_o(scan_step_o));
`default_nettype wire

// *** tb/kms_matrix_model.sv ***
// Purpose: passive key matrix with pull-ups
// Assumes: line code 6 is ground
// Notes:   no chained shorts through two keys
`timescale 1ns/100ps
`default_nettype none
module kms_matrix_model (
    // pins
    input  wire logic [5:0]  key_line_o,
    input  wire logic [5:0]  key_line_oe_n_o,
    output logic      [5:0]  key_line_i,
    // closed keys, bits as key_down_o
    input  wire logic [18:0] closed_i
);
    // ----------
    // wiring: first line code (6 for ground), second line code
    // ----------
    localparam logic [5:0] PAIR [19] = '{6'h05, 6'h04, 6'h03, 6'h02,
        6'h0b, 6'h0a, 6'h0d, 6'h35, 6'h0c, 6'h33, 6'h01, 6'h32, 6'h30,
        6'h15, 6'h14, 6'h13, 6'h34, 6'h31, 6'h25};
    always_comb begin
        logic [5:0] s;
        logic [5:0] lo;
        logic [2:0] a;
        logic [2:0] b;
        s = ~key_line_oe_n_o & ~key_line_o;
        lo = s;
        for (int k = 0; k < 19; k++) begin
            a = PAIR[k][5:3];
            b = PAIR[k][2:0];
            if (closed_i[k] && a == 3'h6) begin
                lo[b] = 1'b1;
            end else if (closed_i[k]) begin
                lo[b] = lo[b] | s[a];
                lo[a] = lo[a] | s[b];
            end
        end
        key_line_i = ~lo;
    end
endmodule : kms_matrix_model
`default_nettype wire

// *** tb/keypad_matrix_scanner_test.sv ***
// Purpose: self-checking bench for kms_scanner
// Assumes: pass of 30 cycles
// Notes:   ground keys ghost onto higher columns, except key bit 12 on line bit 0
`timescale 1ns/100ps
`default_nettype none
module keypad_matrix_scanner_test;
    import kms_pkg::*;
    logic        mclk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        ce_i = 1'b1;
    logic [5:0]  key_line_i;
    logic [5:0]  key_line_o;
    logic [5:0]  key_line_oe_n_o;
    logic [18:0] key_down_o;
    logic [18:0] closed;
    logic        scan_done_o;
    logic [2:0]  scan_step_o;
    logic [2:0]  held;
    int          fails = 0;
    int          tests_run = 0;
    // ----------
    // result per single closed key, ghosts included
    // ----------
    localparam logic [18:0] EXP [19] = '{19'h00001, 19'h00002, 19'h00004,
        19'h00008, 19'h00010, 19'h00020, 19'h00040, 19'h420c1, 19'h00100,
        19'h08214, 19'h00400, 19'h00828, 19'h01000, 19'h02000, 19'h04000,
        19'h08000, 19'h14102, 19'h20400, 19'h40000};
    kms_scanner #(.SETTLE_CYC(5)) kms_scanner_i (.mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i), .ce_i(ce_i), .key_line_i(key_line_i),
        .key_line_o(key_line_o), .key_line_oe_n_o(key_line_oe_n_o),
        .key_down_o(key_down_o), .scan_done_o(scan_done_o),
        .scan_step_o(scan_step_o));
    kms_matrix_model kms_matrix_model_i (.key_line_o(key_line_o),
        .key_line_oe_n_o(key_line_oe_n_o), .key_line_i(key_line_i),
        .closed_i(closed));
    initial begin
        forever #5 mclk_i = ~mclk_i;
    end
    task automatic check_keys(input string n, input logic [18:0] e, g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : check_keys
    task automatic check_bits(input string n, input logic [5:0] e, g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : check_bits
    task automatic wait_done();
        int c;
        c = 0;
        do begin
            @(posedge mclk_i);
            #1;
            c++;
        end while (scan_done_o !== 1'b1 && c < 100);
        if (c >= 100) fails++;
    endtask : wait_done
    task automatic finish_test();
        $display("fails %0d tests_run %0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finish_test
    initial begin
        closed = 19'h00000;
        repeat (10) @(posedge mclk_i);
        #1 sys_rst_i = 1'b0;
        for (int i = 0; i <= 19; i++) begin
            closed = (i < 19) ? 19'h00001 << i : 19'h00000;
            wait_done();
            wait_done();
            check_keys("keys", (i < 19) ? EXP[i] : 19'h0, key_down_o);
        end
        closed = 19'h09000;
        wait_done();
        wait_done();
        check_keys("two keys", 19'h09000, key_down_o);
        ce_i = 1'b0;
        held = scan_step_o;
        repeat (20) @(posedge mclk_i);
        #1 check_bits("frozen", {3'h0, held}, {3'h0, scan_step_o});
        ce_i = 1'b1;
        wait_done();
        #20 sys_rst_i = 1'b1;
        repeat (3) @(posedge mclk_i);
        #1 check_keys("reset keys", 19'h00000, key_down_o);
        check_bits("reset lines", 6'h3f, key_line_oe_n_o);
        check_bits("reset step", 6'h00, {3'h0, scan_step_o});
        sys_rst_i = 1'b0;
        finish_test();
    end
    initial begin
        #100000;
        fails++;
        finish_test();
    end
endmodule : keypad_matrix_scanner_test
`default_nettype wire
